// file: hw/rcd_pkg.sv
// constants shared by the residual current and weld monitor
package rcd_pkg;
  localparam int CLK_HZ = 100_000_000;
  // converter sample rate, samples per second
  localparam int SAMPLE_RATE = 25_000;
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE;
  // extreme-value window, ms
  localparam int WINDOW_MS = 10;
  localparam int WINDOW_SAMPLES = SAMPLE_RATE * WINDOW_MS / 1000;
  // contact settling before weld check, ms
  localparam int SETTLE_MS = 50;
  localparam int SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;
  localparam int SAMPLE_W = 10;
  // reset values of the trip settings (codes of a 10-bit 1.5 V converter)
  localparam logic [9:0] AC_TRIP_RST = 10'h199;
  localparam logic [9:0] DC_TRIP_RST = 10'h088;
  localparam logic [9:0] HYST_RST = 10'h044;
endpackage

// file: hw/sync_if.sv
// synchronised inputs passed from the synchroniser to the monitor
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
  logic saturation;
  logic senseA;
  logic senseB;
  modport source (output saturation, output senseA, output senseB);
  modport sink (input saturation, input senseA, input senseB);
endinterface
`default_nettype wire

// file: hw/input_sync.sv
// two-stage synchronisers for the asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module input_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // raw inputs
  input wire logic [WIDTH-1:0] raw,
  // synchronised outputs
  sync_if.source out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end
        else
        begin
          stage1[i] <= raw[i];
          stage2[i] <= stage1[i];
        end
      end
    end
  endgenerate

  assign out.saturation = stage2[0];
  assign out.senseA = stage2[1];
  assign out.senseB = stage2[2];
endmodule
`default_nettype wire

// file: hw/residual_current_and_weld_monitor.sv
// fluxgate excitation, residual fault trip and relay weld check
`timescale 1ns/1ps
`default_nettype none
module residual_current_and_weld_monitor #(
  parameter int SETTLE = rcd_pkg::SETTLE_CYCLES,
  parameter int SAMPLE_PERIOD = rcd_pkg::SAMPLE_CYCLES,
  parameter int WINDOW_LEN = rcd_pkg::WINDOW_SAMPLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // fluxgate excitation
  input wire logic saturationIn,
  output logic bridgeCtrlA,
  output logic bridgeCtrlB,
  // converter interface
  output logic sampleRequest,
  input wire logic sampleValid,
  input wire logic [rcd_pkg::SAMPLE_W-1:0] sampleData,
  // trip settings
  input wire logic [rcd_pkg::SAMPLE_W-1:0] acTripLevel,
  input wire logic [rcd_pkg::SAMPLE_W-1:0] dcTripLevel,
  input wire logic [rcd_pkg::SAMPLE_W-1:0] hystLevel,
  input wire logic settingsLoad,
  // relay and weld check
  input wire logic relayCommand,
  input wire logic line_sense_a,
  input wire logic line_sense_b,
  input wire logic weldClear,
  output logic relayEnable,
  output logic faultTrip,
  output logic faultIsAc,
  output logic weldFault,
  output logic weldCheckDone
);
  localparam int SW = rcd_pkg::SAMPLE_W;
  localparam int SPW = $clog2(SAMPLE_PERIOD + 1);
  localparam int WNW = $clog2(WINDOW_LEN + 1);
  localparam int STW = $clog2(SETTLE + 1);

  typedef enum logic [2:0] {
    RLY_OPEN = 3'b001,
    RLY_CLOSED = 3'b010,
    RLY_SETTLE = 3'b100
  } relay_e;

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  sync_if syncd();

  input_sync #(.WIDTH(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .raw({line_sense_b, line_sense_a, saturationIn}),
    .out(syncd)
  );

  // ------------------------------------------------------------
  // excitation direction toggle
  // ------------------------------------------------------------
  logic satPrev;
  logic direction_toggle_flop;
  wire satRise = syncd.saturation & ~satPrev;

  // edge detector on the synchronised comparator level
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      satPrev <= 1'b0;
    end
    else
    begin
      satPrev <= syncd.saturation;
    end
  end

  // inverted state feeds its own data input
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      direction_toggle_flop <= 1'b0;
    end
    else if (satRise)
    begin
      direction_toggle_flop <= ~direction_toggle_flop;
    end
  end

  // both bridge controls reload from the flop state together
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      bridgeCtrlA <= 1'b0;
      bridgeCtrlB <= 1'b1;
    end
    else if (satRise)
    begin
      bridgeCtrlA <= ~direction_toggle_flop;
      bridgeCtrlB <= direction_toggle_flop;
    end
  end

  // ------------------------------------------------------------
  // sample pacing
  // ------------------------------------------------------------
  logic [SPW-1:0] sampleCount;
  wire sampleTick = (sampleCount == SPW'(SAMPLE_PERIOD - 1));

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sampleCount <= '0;
      sampleRequest <= 1'b0;
    end
    else
    begin
      sampleCount <= sampleTick ? '0 : sampleCount + 1'b1;
      sampleRequest <= sampleTick;
    end
  end

  // ------------------------------------------------------------
  // trip settings
  // ------------------------------------------------------------
  logic [SW-1:0] acTrip;
  logic [SW-1:0] dcTrip;
  logic [SW-1:0] hyst;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      acTrip <= rcd_pkg::AC_TRIP_RST;
      dcTrip <= rcd_pkg::DC_TRIP_RST;
      hyst <= rcd_pkg::HYST_RST;
    end
    else if (settingsLoad)
    begin
      acTrip <= acTripLevel;
      dcTrip <= dcTripLevel;
      hyst <= hystLevel;
    end
  end

  // ------------------------------------------------------------
  // window peak and trough
  // ------------------------------------------------------------
  logic [SW-1:0] peak;
  logic [SW-1:0] trough;
  logic [WNW-1:0] winCount;
  wire winEnd = sampleValid & (winCount == WNW'(WINDOW_LEN - 1));
  wire [SW-1:0] next_peak = (sampleData > peak) ? sampleData : peak;
  wire [SW-1:0] next_trough = (sampleData < trough) ? sampleData : trough;

  // rectified signal: AC dips to near zero, DC holds its trough high
  wire isDc = (next_trough >= dcTrip);
  wire isAc = ~isDc & (next_peak >= acTrip);
  wire tripSet = isDc | isAc;
  wire tripRelease = (next_peak < hyst);

  // running extremes, restarted at each window end
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      peak <= '0;
      trough <= '1;
    end
    else if (winEnd)
    begin
      peak <= '0;
      trough <= '1;
    end
    else if (sampleValid)
    begin
      peak <= next_peak;
      trough <= next_trough;
    end
  end

  // samples taken in the current window
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      winCount <= '0;
    end
    else if (winEnd)
    begin
      winCount <= '0;
    end
    else if (sampleValid)
    begin
      winCount <= winCount + 1'b1;
    end
  end

  // trip judged once per window, closing sample included
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      faultTrip <= 1'b0;
      faultIsAc <= 1'b0;
    end
    else if (winEnd & tripSet)
    begin
      faultTrip <= 1'b1;
      faultIsAc <= isAc;
    end
    else if (winEnd & tripRelease)
    begin
      faultTrip <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // relay control and weld check
  // ------------------------------------------------------------
  relay_e relayState;
  relay_e next_relayState;
  logic [STW-1:0] settleCount;
  wire closeReq = relayCommand & ~faultTrip & ~weldFault;
  wire settled = (settleCount == STW'(SETTLE - 1));
  wire lineLive = syncd.senseA | syncd.senseB;

  always_comb
  begin
    next_relayState = relayState;
    unique case (relayState)
      RLY_OPEN: if (closeReq) next_relayState = RLY_CLOSED;
      RLY_CLOSED: if (!closeReq) next_relayState = RLY_SETTLE;
      RLY_SETTLE: if (settled) next_relayState = RLY_OPEN;
      default: next_relayState = RLY_OPEN;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      relayState <= RLY_OPEN;
    end
    else
    begin
      relayState <= next_relayState;
    end
  end

  // settle delay counts only while the relay is releasing
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      settleCount <= '0;
    end
    else
    begin
      settleCount <= (relayState == RLY_SETTLE) ? settleCount + 1'b1 : '0;
    end
  end

  // solenoid enable and end-of-settle pulse
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      relayEnable <= 1'b0;
      weldCheckDone <= 1'b0;
    end
    else
    begin
      relayEnable <= (next_relayState == RLY_CLOSED);
      weldCheckDone <= (relayState == RLY_SETTLE) & settled;
    end
  end

  // sticky weld flag, a set beats a clear
  wire weldSeen = (relayState == RLY_SETTLE) & settled & lineLive;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      weldFault <= 1'b0;
    end
    else if (weldSeen)
    begin
      weldFault <= 1'b1;
    end
    else if (weldClear)
    begin
      weldFault <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: testbench/rcd_monitor_sva.sv
// port assertions for the residual current and weld monitor
`timescale 1ns/1ps
`default_nettype none
module rcd_monitor_sva #(
  parameter int SETTLE = 20,
  parameter int SAMPLE_PERIOD = 10
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // watched ports
  input wire logic saturationIn,
  input wire logic bridgeCtrlA,
  input wire logic bridgeCtrlB,
  input wire logic sampleRequest,
  input wire logic sampleValid,
  input wire logic relayCommand,
  input wire logic relayEnable,
  input wire logic faultTrip,
  input wire logic weldFault,
  input wire logic weldCheckDone
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence satRise;
    $rose(saturationIn);
  endsequence
  chk_bridge_pair: assert property (bridgeCtrlB != bridgeCtrlA)
    else $error("bridge pair");
  chk_bridge_flip: assert property (
    satRise |-> ##[2:3] $changed(bridgeCtrlA)) else $error("no flip");
  chk_sample_pace: assert property (
    sampleRequest |-> ##SAMPLE_PERIOD sampleRequest) else $error("pace");
  chk_trip_window: assert property (
    $changed(faultTrip) |-> $past(sampleValid)) else $error("trip time");
  chk_relay_open: assert property (
    !relayCommand || faultTrip || weldFault |=> !relayEnable)
    else $error("relay held");
  chk_relay_close: assert property (
    $rose(relayEnable) |-> $past(relayCommand) && !$past(weldFault))
    else $error("bad close");
  chk_weld_time: assert property (
    $fell(relayEnable) |-> ##SETTLE weldCheckDone) else $error("no check");
  chk_weld_cause: assert property (
    $rose(weldFault) |-> weldCheckDone) else $error("weld cause");
endmodule
bind residual_current_and_weld_monitor rcd_monitor_sva #(
  .SETTLE(SETTLE), .SAMPLE_PERIOD(SAMPLE_PERIOD)
) i_rcd_monitor_sva (
  .clk_sys, .rst, .saturationIn, .bridgeCtrlA, .bridgeCtrlB, .sampleRequest,
  .sampleValid, .relayCommand, .relayEnable, .faultTrip, .weldFault,
  .weldCheckDone
);
`default_nettype wire

// file: testbench/rcd_partner.sv
// converter, fluxgate coil and contact sense model
`timescale 1ns/1ps
`default_nettype none
module rcd_partner (
  // clock, reset and bench controls
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic dcBias,
  input wire logic slow,
  input wire logic welded,
  input wire logic [9:0] level,
  // from the block
  input wire logic bridgeCtrlA,
  input wire logic sampleRequest,
  input wire logic relayEnable,
  // to the block
  output logic saturationIn,
  output logic sampleValid,
  output logic [9:0] sampleData,
  output logic line_sense_a,
  output logic line_sense_b
);
  int coil = 0;
  logic [1:0] reqPipe = 2'h0;
  wire logic answer = slow ? reqPipe[1] : sampleRequest;
  initial {saturationIn, sampleValid, sampleData, line_sense_a} = '0;
  initial line_sense_b = 1'b0;
  // idle data alternates each cycle between the last code and its inverse
  always @(negedge clk_sys)
  begin
    reqPipe <= {reqPipe[0], sampleRequest};
    coil <= rst ? 0 : coil + (bridgeCtrlA ? (dcBias ? 2 : 1) : -1);
    saturationIn <= coil > 8 || coil < -8;
    sampleValid <= answer;
    sampleData <= answer ? level : ~sampleData;
    line_sense_a <= relayEnable || welded;
    line_sense_b <= relayEnable || welded;
  end
endmodule
`default_nettype wire

// file: testbench/residual_current_and_weld_monitor_tb.sv
// self-checking bench for the residual current and weld monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH %0t %h %h", $time, (a), (e)); end end
module residual_current_and_weld_monitor_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic dcBias = 1'b0;
  logic slow = 1'b0;
  logic welded = 1'b0;
  logic settingsLoad = 1'b0;
  logic relayCommand = 1'b0;
  logic weldClear = 1'b0;
  logic [9:0] level = 10'h000;
  logic [9:0] dcTripLevel = rcd_pkg::DC_TRIP_RST;
  logic [9:0] acTripLevel = rcd_pkg::AC_TRIP_RST;
  logic [9:0] hystLevel = rcd_pkg::HYST_RST;
  logic [9:0] sampleData;
  logic saturationIn, bridgeCtrlA, bridgeCtrlB, sampleRequest, sampleValid;
  logic line_sense_a, line_sense_b, relayEnable, faultTrip, faultIsAc;
  logic weldFault, weldCheckDone;
  int failures = 0;
  int comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  residual_current_and_weld_monitor #(
    .SETTLE(20), .SAMPLE_PERIOD(10), .WINDOW_LEN(8)
  ) i_residual_current_and_weld_monitor (
    .clk_sys, .rst, .saturationIn, .bridgeCtrlA, .bridgeCtrlB, .sampleRequest,
    .sampleValid, .sampleData, .acTripLevel,
    .dcTripLevel, .hystLevel, .settingsLoad, .relayCommand,
    .line_sense_a, .line_sense_b, .weldClear, .relayEnable, .faultTrip,
    .faultIsAc, .weldFault, .weldCheckDone
  );
  rcd_partner i_rcd_partner (
    .clk_sys, .rst, .dcBias, .slow, .welded, .level, .bridgeCtrlA,
    .sampleRequest, .relayEnable, .saturationIn, .sampleValid, .sampleData,
    .line_sense_a, .line_sense_b
  );
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic waitFor(ref logic s, input logic v);
    int n;
    n = 300;
    while (s !== v && n-- > 0) @(negedge clk_sys);
  endtask
  task automatic checkReset;
    `CHK({bridgeCtrlA, bridgeCtrlB, relayEnable, faultTrip}, 4'h4)
  endtask
  task automatic checkDuty(input logic bias);
    int hi;
    int lo;
    dcBias = bias;
    hi = 0;
    lo = 0;
    waitFor(bridgeCtrlA, 1'b0);
    waitFor(bridgeCtrlA, 1'b1);
    for (; bridgeCtrlA === 1'b1 && hi < 300; hi++) cycles(1);
    for (; bridgeCtrlA === 1'b0 && lo < 300; lo++) cycles(1);
    `CHK(lo == hi && hi > 0, !bias)
    `CHK(lo > hi, bias)
  endtask
  task automatic relayCycle(input logic weld);
    welded = weld;
    relayCommand = 1'b1;
    cycles(2);
    `CHK(relayEnable, 1'b1)
    relayCommand = 1'b0;
    cycles(2);
    `CHK(relayEnable, 1'b0)
    waitFor(weldCheckDone, 1'b1);
    `CHK({weldCheckDone, weldFault}, {1'b1, weld})
  endtask
  task automatic weldLockout;
    relayCommand = 1'b1;
    cycles(3);
    `CHK(relayEnable, 1'b0)
    relayCommand = 1'b0;
    welded = 1'b0;
    weldClear = 1'b1;
    cycles(1);
    weldClear = 1'b0;
    `CHK(weldFault, 1'b0)
  endtask
  task automatic feed(input logic [9:0] a, input logic [9:0] b);
    repeat (6)
    begin
      level = a;
      cycles(15);
      level = b;
      cycles(15);
    end
  endtask
  task automatic loadLevels(input logic [9:0] ac, input logic [9:0] dc,
    input logic [9:0] hy);
    acTripLevel = ac;
    dcTripLevel = dc;
    hystLevel = hy;
    settingsLoad = 1'b1;
    cycles(1);
    settingsLoad = 1'b0;
  endtask
  task automatic tripTests;
    loadLevels(rcd_pkg::AC_TRIP_RST, 10'h0A0, rcd_pkg::HYST_RST);
    feed(rcd_pkg::DC_TRIP_RST, rcd_pkg::DC_TRIP_RST);
    `CHK(faultTrip, 1'b0)
    loadLevels(rcd_pkg::AC_TRIP_RST, rcd_pkg::DC_TRIP_RST, rcd_pkg::HYST_RST);
    feed(rcd_pkg::DC_TRIP_RST, rcd_pkg::DC_TRIP_RST);
    `CHK({faultTrip, faultIsAc}, 2'h2)
    feed(10'h050, 10'h050);
    `CHK(faultTrip, 1'b1)
    feed(10'h000, 10'h000);
    `CHK(faultTrip, 1'b0)
    slow = 1'b1;
    loadLevels(10'h300, rcd_pkg::DC_TRIP_RST, rcd_pkg::HYST_RST);
    feed(10'h000, rcd_pkg::AC_TRIP_RST);
    `CHK(faultTrip, 1'b0)
    loadLevels(rcd_pkg::AC_TRIP_RST, rcd_pkg::DC_TRIP_RST, rcd_pkg::HYST_RST);
    feed(10'h000, rcd_pkg::AC_TRIP_RST);
    `CHK({faultTrip, faultIsAc}, 2'h3)
    loadLevels(rcd_pkg::AC_TRIP_RST, rcd_pkg::DC_TRIP_RST, 10'h060);
    feed(10'h050, 10'h050);
    `CHK(faultTrip, 1'b0)
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    cycles(10);
    rst = 1'b0;
    checkReset;
    checkDuty(1'b0);
    checkDuty(1'b1);
    relayCycle(1'b0);
    relayCycle(1'b1);
    weldLockout;
    tripTests;
    conclude;
  end
  // run needs about 1500 cycles; twenty times that
  initial
  begin
    #300000;
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
